/* rtl/adsp_pkg.sv */
`default_nettype none
package adsp_pkg;
    // Clock and timing
    localparam int CLK_MHZ = 25;
    localparam int NS_PER_US = 1000;
    localparam int SCLK_HALF_NS = 125;
    localparam int CS_SETUP_NS = 125;
    localparam int SCLK_HALF_CYC =
        (SCLK_HALF_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
    localparam int CS_SETUP_CYC =
        (CS_SETUP_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
    localparam int CS_HIGH_MCLK = 6;
    localparam int DOUT_IGNORE_MCLK = 10;
    localparam int GAP_CYC = (DOUT_IGNORE_MCLK > CS_HIGH_MCLK) ?
        DOUT_IGNORE_MCLK : CS_HIGH_MCLK;
    localparam int XTAL_START_MS = 20;
    localparam int STARTUP_CYC = XTAL_START_MS * CLK_MHZ * NS_PER_US;
    localparam int WORD_CYC = 2000;
    localparam int TMR_W = 4;

    // Widths
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam int CONV_W = 24;
    localparam int CNT_W = 5;
    localparam int VIEW_W = 5;

    // Bit counts within a frame or result fetch, and the lead bit values
    localparam logic [4:0] ADDR_LAST = 5'h07;
    localparam logic [4:0] FRAME_LAST = 5'h0f;
    localparam logic [4:0] FRAME_BITS = 5'h10;
    localparam logic [4:0] CONV_LAST = 5'h17;
    localparam logic [4:0] CONV_BITS = 5'h18;
    localparam logic DIR_WRITE = 1'h1;
    localparam logic DIR_READ = 1'h0;

    // Register map and fields
    localparam logic [6:0] REG_SDO_LSS = 7'h02;
    localparam logic [6:0] REG_STANDBY = 7'h03;
    localparam logic [6:0] REG_CONV_CTRL = 7'h04;
    localparam int BIT_SDO_DIS = 1;
    localparam int BIT_LSS = 0;
    localparam int BIT_STANDBY = 0;
    localparam logic [1:0] CONV_STOP = 2'h0;
    localparam logic [1:0] CONV_SINGLE = 2'h1;
    localparam logic [1:0] CONV_CONT = 2'h2;

    // Result coding
    localparam logic [23:0] FS_POS = 24'h7fffff;
    localparam logic [23:0] FS_NEG = 24'h800000;
    localparam logic [1:0] SETTLE_LAST = 2'h3;

    typedef enum logic [2:0] {
        H_IDLE = 3'h0,
        H_SETUP = 3'h1,
        H_SHIFT = 3'h2,
        H_CONV = 3'h3,
        H_GAP = 3'h4
    } adsp_hstate_e;
endpackage : adsp_pkg
`default_nettype wire

/* rtl/adsp_link_if.sv */
`default_nettype none
interface adsp_link_if;
    logic sclk;
    logic cs_n;
    logic sdi;
    logic dout_drv;
    logic dout_oe;
    logic data_out_ready_n;

    // Pulled high while the device does not drive
    assign data_out_ready_n = dout_oe ? dout_drv : 1'h1;

    modport device (input sclk, input cs_n, input sdi,
                    output dout_drv, output dout_oe);
    modport host (output sclk, output cs_n, output sdi,
                  input data_out_ready_n);
endinterface : adsp_link_if
`default_nettype wire

/* rtl/adsp_sync.sv */
`default_nettype none
module adsp_sync #(
    parameter int W = 1
) (
    // Destination clock
    input wire logic clk,
    // Level in and out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clk) begin
        meta_reg <= d;
        q <= meta_reg;
    end
endmodule : adsp_sync
`default_nettype wire

/* rtl/adsp_device.sv */
`default_nettype none
// How it works
// - Write: address byte, lead bit 1
// - Read: address byte, lead bit 0
// - Host drops chip select with clock low
// - Bits captured on rising serial clock
// - Written byte committed on master clock
// - Host ignores ready pin ten clocks
// - One frame per write, six-clock gap
// - Read shifts selected byte out, sixteen clocks
// - Ready pin low when result waits
// - Host fetches result with select high
// - MSB on first rising edge, advance each
// - Host holds clock low after result
// - Over-range resets filter, quarter ready rate
// - Twos complement, saturate at full scale
// - Power-down release resets device logic
// - Power-down low stops everything; link side still answers read frames
// - Resume only after clock startup delay
// - Standby bit lowers power, quick exit
// - Control bit drives open-drain switch
// - Standby stops conversions
module adsp_device #(
    parameter int STARTUP_CYCLES = adsp_pkg::STARTUP_CYC,
    parameter int WORD_CYCLES = adsp_pkg::WORD_CYC
) (
    // Master clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Serial link
    adsp_link_if.device link,
    // Power and analog side
    input wire logic power_down_n,
    input wire logic [adsp_pkg::CONV_W-1:0] sample,
    input wire logic over_range_pos,
    input wire logic over_range_neg,
    // Switch and status
    output logic low_side_switch_oe,
    output logic low_side_switch_o,
    output logic powered_up,
    output logic standby_active
);
    import adsp_pkg::*;

    localparam int SU_W = $clog2(STARTUP_CYCLES + 1);
    localparam int WD_W = $clog2(WORD_CYCLES + 1);

    // Link side state
    logic [CNT_W-1:0] bit_cnt;
    logic [ADDR_W-1:0] sh_in;
    logic [ADDR_W-1:0] addr_cap;
    logic dir_cap;
    logic [DATA_W-1:0] rd_byte;
    logic [DATA_W-1:0] wr_data_cap;
    logic dout_rd_reg;
    logic wr_pend_reg;
    logic [CNT_W-1:0] cv_cnt;
    logic [CONV_W-2:0] cv_sh;
    logic dout_cv_reg;
    logic cv_done_reg;
    logic [VIEW_W-1:0] view_s;

    // Master clock side state
    logic cs_s;
    logic pd_s;
    logic wr_pend_s;
    logic cv_done_s;
    logic int_rst;
    logic [SU_W-1:0] start_cnt;
    logic powered_reg;
    logic wr_ack_reg;
    logic commit;
    logic dout_en_reg;
    logic lss_reg;
    logic standby_reg;
    logic [1:0] conv_ctrl_reg;
    logic running;
    logic [WD_W-1:0] per_cnt;
    logic conv_tick;
    logic [1:0] settle_reg;
    logic word_out;
    logic over_range;
    logic [CONV_W-1:0] word_val;
    logic [CONV_W-1:0] conv_word_reg;
    logic rdy_n_reg;

    function automatic logic [DATA_W-1:0] read_sel(
        input logic [ADDR_W-1:0] a,
        input logic [VIEW_W-1:0] v
    );
        logic [DATA_W-1:0] r;
        r = '0;
        unique case (a)
            REG_SDO_LSS: begin
                r[BIT_SDO_DIS] = v[1];
                r[BIT_LSS] = v[0];
            end
            REG_STANDBY: r[BIT_STANDBY] = v[2];
            REG_CONV_CTRL: r[1:0] = v[4:3];
            default: r = '0;
        endcase
        return r;
    endfunction : read_sel

    // Register view crosses into the link clock
    adsp_sync #(.W(VIEW_W)) u_view_sync (
        .clk(link.sclk),
        .d({conv_ctrl_reg, standby_reg, ~dout_en_reg, lss_reg}),
        .q(view_s)
    );

    // Frame bit counter, cleared by the frame's own select
    always_ff @(posedge link.sclk or posedge link.cs_n) begin
        if (link.cs_n) begin
            bit_cnt <= '0;
            dout_rd_reg <= 1'h1;
        end else begin
            if (bit_cnt != FRAME_BITS) begin
                bit_cnt <= bit_cnt + 5'h01;
            end
            if (bit_cnt > ADDR_LAST && dir_cap == DIR_READ) begin
                dout_rd_reg <= rd_byte[DATA_W-1];
            end
        end
    end

    // Serial capture of address and data
    always_ff @(posedge link.sclk) begin
        if (!link.cs_n) begin
            sh_in <= {sh_in[ADDR_W-2:0], link.sdi};
            if (bit_cnt == ADDR_LAST) begin
                dir_cap <= sh_in[ADDR_W-1];
                addr_cap <= {sh_in[ADDR_W-2:0], link.sdi};
                rd_byte <= read_sel({sh_in[ADDR_W-2:0], link.sdi}, view_s);
            end else if (bit_cnt > ADDR_LAST) begin
                rd_byte <= {rd_byte[DATA_W-2:0], 1'h0};
            end
            if (bit_cnt == FRAME_LAST) begin
                wr_data_cap <= {sh_in, link.sdi};
            end
        end
    end

    // Write pending flag, cleared by the master side acknowledge
    always_ff @(posedge link.sclk or posedge wr_ack_reg) begin
        if (wr_ack_reg) begin
            wr_pend_reg <= 1'h0;
        end else if (!link.cs_n && bit_cnt == FRAME_LAST &&
                     dir_cap == DIR_WRITE) begin
            wr_pend_reg <= 1'h1;
        end
    end

    // Conversion word shifting with select high
    always_ff @(posedge link.sclk or posedge rdy_n_reg) begin
        if (rdy_n_reg) begin
            cv_cnt <= '0;
            cv_done_reg <= 1'h0;
        end else if (link.cs_n && cv_cnt != CONV_BITS) begin
            cv_cnt <= cv_cnt + 5'h01;
            if (cv_cnt == CONV_LAST) begin
                cv_done_reg <= 1'h1;
            end
        end
    end

    always_ff @(posedge link.sclk) begin
        if (link.cs_n && cv_cnt == '0) begin
            {dout_cv_reg, cv_sh} <= conv_word_reg;
        end else if (link.cs_n && cv_cnt != CONV_BITS) begin
            dout_cv_reg <= cv_sh[CONV_W-2];
            cv_sh <= {cv_sh[CONV_W-3:0], 1'h0};
        end
    end

    // Shared pin: read data in a frame, else ready or result
    assign link.dout_drv = !link.cs_n ? dout_rd_reg :
        (cv_cnt != '0 ? dout_cv_reg : rdy_n_reg);
    assign link.dout_oe = dout_en_reg;

    // Master clock crossings
    adsp_sync #(.W(4)) u_ctl_sync (
        .clk(clk),
        .d({link.cs_n, power_down_n, wr_pend_reg, cv_done_reg}),
        .q({cs_s, pd_s, wr_pend_s, cv_done_s})
    );

    // Power-down holds the master clock side logic in reset
    assign int_rst = !resetn || !pd_s;

    // Startup delay after power-down release
    always_ff @(posedge clk) begin
        if (int_rst) begin
            start_cnt <= '0;
            powered_reg <= 1'h0;
        end else if (!powered_reg) begin
            if (start_cnt == SU_W'(STARTUP_CYCLES - 1)) begin
                powered_reg <= 1'h1;
            end else begin
                start_cnt <= start_cnt + SU_W'(1);
            end
        end
    end

    // Write commit after select returns high
    assign commit = wr_pend_s && cs_s && !wr_ack_reg;

    always_ff @(posedge clk) begin
        if (int_rst) begin
            wr_ack_reg <= 1'h1;
        end else if (commit) begin
            wr_ack_reg <= 1'h1;
        end else if (!wr_pend_s) begin
            wr_ack_reg <= 1'h0;
        end
    end

    // Control registers
    always_ff @(posedge clk) begin
        if (int_rst) begin
            dout_en_reg <= 1'h1;
            lss_reg <= 1'h0;
            standby_reg <= 1'h0;
            conv_ctrl_reg <= CONV_STOP;
        end else if (commit && powered_reg) begin
            unique case (addr_cap)
                REG_SDO_LSS: begin
                    dout_en_reg <= !wr_data_cap[BIT_SDO_DIS];
                    lss_reg <= wr_data_cap[BIT_LSS];
                end
                REG_STANDBY: begin
                    standby_reg <= wr_data_cap[BIT_STANDBY];
                end
                REG_CONV_CTRL: conv_ctrl_reg <= wr_data_cap[1:0];
                default: conv_ctrl_reg <= conv_ctrl_reg;
            endcase
        end else if (word_out && conv_ctrl_reg == CONV_SINGLE) begin
            conv_ctrl_reg <= CONV_STOP;
        end
    end

    // Conversion timing
    assign running = powered_reg && !standby_reg &&
        (conv_ctrl_reg == CONV_SINGLE ||
         conv_ctrl_reg == CONV_CONT);
    assign conv_tick = running && per_cnt == WD_W'(WORD_CYCLES - 1);
    assign over_range = over_range_pos || over_range_neg;
    assign word_out = conv_tick && settle_reg == '0;

    always_ff @(posedge clk) begin
        if (int_rst || !running || commit) begin
            per_cnt <= '0;
        end else if (conv_tick) begin
            per_cnt <= '0;
        end else begin
            per_cnt <= per_cnt + WD_W'(1);
        end
    end

    // Filter restart on over-range
    always_ff @(posedge clk) begin
        if (int_rst) begin
            settle_reg <= '0;
        end else if (conv_tick) begin
            if (settle_reg != '0) begin
                settle_reg <= settle_reg - 2'h1;
            end else if (over_range) begin
                settle_reg <= SETTLE_LAST;
            end
        end
    end

    // Saturated twos complement result
    assign word_val = over_range_pos ? FS_POS :
        (over_range_neg ? FS_NEG : sample);

    // Ready indication and result hold
    always_ff @(posedge clk) begin
        if (int_rst) begin
            rdy_n_reg <= 1'h1;
            conv_word_reg <= '0;
        end else if (cv_done_s) begin
            rdy_n_reg <= 1'h1;
        end else if (word_out && rdy_n_reg) begin
            rdy_n_reg <= 1'h0;
            conv_word_reg <= word_val;
        end
    end

    // Open-drain switch pulls low while on
    always_ff @(posedge clk) begin
        if (int_rst) begin
            low_side_switch_oe <= 1'h0;
        end else begin
            low_side_switch_oe <= lss_reg;
        end
    end

    assign low_side_switch_o = 1'h0;
    assign powered_up = powered_reg;
    assign standby_active = standby_reg;
endmodule : adsp_device
`default_nettype wire

/* rtl/adsp_host.sv */
`default_nettype none
module adsp_host (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Serial link
    adsp_link_if.host link,
    // Register access requests
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_write,
    input wire logic [adsp_pkg::ADDR_W-1:0] cmd_addr,
    input wire logic [adsp_pkg::DATA_W-1:0] cmd_data,
    // Answers
    output logic rsp_valid,
    output logic rsp_conv,
    output logic [adsp_pkg::CONV_W-1:0] rsp_data
);
    import adsp_pkg::*;

    adsp_hstate_e state;
    logic [TMR_W-1:0] tmr;
    logic [CNT_W-1:0] edges;
    logic [FRAME_BITS-1:0] tx;
    logic [CONV_W-1:0] rx;
    logic is_read;
    logic sclk_reg;
    logic cs_n_reg;
    logic sdi_reg;
    logic dout_s;
    logic half_done;
    logic last_edge;

    adsp_sync #(.W(1)) u_dout_sync (
        .clk(clk),
        .d(link.data_out_ready_n),
        .q(dout_s)
    );

    assign half_done = tmr == TMR_W'(SCLK_HALF_CYC - 1);
    assign last_edge = sclk_reg && half_done &&
        edges == (state == H_CONV ? CONV_BITS : FRAME_BITS);

    // Sequencer, serial clock divider and select
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state <= H_IDLE;
            tmr <= '0;
            edges <= '0;
            sclk_reg <= 1'h0;
            cs_n_reg <= 1'h1;
            cmd_ready <= 1'h0;
        end else begin
            unique case (state)
                H_IDLE: begin
                    tmr <= '0;
                    edges <= '0;
                    cmd_ready <= 1'h1;
                    if (cmd_valid && cmd_ready) begin
                        cs_n_reg <= 1'h0;
                        cmd_ready <= 1'h0;
                        state <= H_SETUP;
                    end else if (!dout_s && !cmd_valid) begin
                        cmd_ready <= 1'h0;
                        state <= H_CONV;
                    end
                end
                H_SETUP: begin
                    if (tmr == TMR_W'(CS_SETUP_CYC - 1)) begin
                        tmr <= '0;
                        state <= H_SHIFT;
                    end else begin
                        tmr <= tmr + TMR_W'(1);
                    end
                end
                H_SHIFT, H_CONV: begin
                    if (half_done) begin
                        tmr <= '0;
                        sclk_reg <= !sclk_reg;
                        if (!sclk_reg) begin
                            edges <= edges + 5'h01;
                        end
                        if (last_edge) begin
                            cs_n_reg <= 1'h1;
                            state <= H_GAP;
                        end
                    end else begin
                        tmr <= tmr + TMR_W'(1);
                    end
                end
                H_GAP: begin
                    if (tmr == TMR_W'(GAP_CYC - 1)) begin
                        state <= H_IDLE;
                    end else begin
                        tmr <= tmr + TMR_W'(1);
                    end
                end
                default: state <= H_IDLE;
            endcase
        end
    end

    // Data shifting and answers
    always_ff @(posedge clk) begin
        if (!resetn) begin
            tx <= '0;
            rx <= '0;
            is_read <= 1'h0;
            sdi_reg <= 1'h0;
            rsp_valid <= 1'h0;
            rsp_conv <= 1'h0;
            rsp_data <= '0;
        end else begin
            rsp_valid <= 1'h0;
            if (state == H_IDLE && cmd_valid && cmd_ready) begin
                tx <= {cmd_write, cmd_addr, cmd_data};
                sdi_reg <= cmd_write;
                is_read <= !cmd_write;
            end else if ((state == H_SHIFT || state == H_CONV) &&
                         half_done && sclk_reg) begin
                tx <= {tx[FRAME_BITS-2:0], 1'h0};
                sdi_reg <= tx[FRAME_BITS-2];
                rx <= {rx[CONV_W-2:0], dout_s};
                if (last_edge) begin
                    rsp_valid <= (state == H_CONV) || is_read;
                    rsp_conv <= state == H_CONV;
                    rsp_data <= (state == H_CONV) ?
                        {rx[CONV_W-2:0], dout_s} :
                        {{(CONV_W-DATA_W){1'h0}},
                         rx[DATA_W-2:0], dout_s};
                end
            end
        end
    end

    assign link.sclk = sclk_reg;
    assign link.cs_n = cs_n_reg;
    assign link.sdi = sdi_reg;
endmodule : adsp_host
`default_nettype wire

/* verif/adsp_link_properties.sv */
`default_nettype none
module adsp_link_properties (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Link signals
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdi,
    input wire logic dout_drv,
    input wire logic dout_oe,
    input wire logic data_out_ready_n
);
    import adsp_pkg::*;
    logic sclk_q;
    logic rdy_q;
    logic [4:0] fr_cnt;
    logic [4:0] cv_cnt;

    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    // Previous pin and clock levels
    always_ff @(posedge clk) begin
        sclk_q <= sclk;
        rdy_q <= data_out_ready_n;
    end

    // Serial clock rises inside a frame
    always_ff @(posedge clk) begin
        if (!resetn || cs_n) begin
            fr_cnt <= 5'h00;
        end else if (sclk && !sclk_q) begin
            fr_cnt <= fr_cnt + 5'h01;
        end
    end

    // Serial clock rises of a result fetch
    always_ff @(posedge clk) begin
        if (!resetn || !cs_n || (rdy_q && !data_out_ready_n)) begin
            cv_cnt <= 5'h00;
        end else if (sclk && !sclk_q) begin
            cv_cnt <= cv_cnt + 5'h01;
        end
    end

    cs_low_sclk_a: assert property (
        $fell(cs_n) |-> !sclk)
        else $error("chip select fell with serial clock high");
    cs_setup_a: assert property (
        $fell(cs_n) |-> !sclk [*4])
        else $error("serial clock rose too soon after select");
    sdi_hold_a: assert property (
        (sclk && !cs_n) |-> $stable(sdi))
        else $error("serial input moved while clock high");
    cs_gap_a: assert property (
        $rose(cs_n) |-> cs_n [*6])
        else $error("chip select high time too short");
    pin_ignore_a: assert property (
        $rose(cs_n) |-> !sclk [*8] ##1 !sclk [*2])
        else $error("result fetch began too soon after frame");
    frame_len_a: assert property (
        $rose(cs_n) |-> fr_cnt == FRAME_BITS)
        else $error("frame did not hold sixteen clocks");
    pin_idle_a: assert property (
        (!cs_n && fr_cnt != 5'h00 && fr_cnt <= ADDR_LAST)
            |-> data_out_ready_n)
        else $error("pin driven low during address byte");
    ready_fetch_a: assert property (
        ($fell(data_out_ready_n) && cs_n) |-> ##[1:200] $rose(sclk))
        else $error("ready result not fetched");
    fetch_len_a: assert property (
        ($rose(sclk) && cs_n) |-> cv_cnt < CONV_BITS)
        else $error("serial clock ran past result word");
endmodule : adsp_link_properties
`default_nettype wire

/* verif/tb_top.sv */
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import adsp_pkg::*;
    localparam int STARTUP = 20;
    localparam int WORD = 400;
    logic clk;
    logic resetn;
    logic power_down_n;
    logic [CONV_W-1:0] sample;
    logic over_range_pos;
    logic over_range_neg;
    logic low_side_switch_oe;
    logic powered_up;
    logic standby_active;
    logic cmd_valid;
    logic cmd_ready;
    logic cmd_write;
    logic [ADDR_W-1:0] cmd_addr;
    logic [DATA_W-1:0] cmd_data;
    logic rsp_valid;
    logic rsp_conv;
    logic [CONV_W-1:0] rsp_data;
    int n_mismatch = 0;
    int n_compared = 0;
    int cyc = 0;

    adsp_link_if link_bus ();
    adsp_device #(.STARTUP_CYCLES(STARTUP), .WORD_CYCLES(WORD))
        adsp_device_i (.clk(clk), .resetn(resetn), .link(link_bus),
        .power_down_n(power_down_n), .sample(sample),
        .over_range_pos(over_range_pos), .over_range_neg(over_range_neg),
        .low_side_switch_oe(low_side_switch_oe), .low_side_switch_o(),
        .powered_up(powered_up), .standby_active(standby_active));
    adsp_host adsp_host_i (.clk(clk), .resetn(resetn), .link(link_bus),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
        .rsp_valid(rsp_valid), .rsp_conv(rsp_conv), .rsp_data(rsp_data));
    adsp_link_properties adsp_link_properties_i (.clk(clk),
        .resetn(resetn), .sclk(link_bus.sclk), .cs_n(link_bus.cs_n),
        .sdi(link_bus.sdi), .dout_drv(link_bus.dout_drv),
        .dout_oe(link_bus.dout_oe),
        .data_out_ready_n(link_bus.data_out_ready_n));

    initial begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic conclude();
        $display("Compared %0d, mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : conclude

    task automatic idle();
        int n;
        n = 0;
        while (cmd_ready !== 1'h1 && n < 2000) begin
            @(negedge clk);
            n++;
        end
    endtask : idle

    task automatic send(input logic wr, input logic [6:0] a,
                        input logic [7:0] d);
        idle();
        cmd_valid = 1'h1;
        cmd_write = wr;
        cmd_addr = a;
        cmd_data = d;
        @(negedge clk);
        cmd_valid = 1'h0;
    endtask : send

    task automatic write(input logic [6:0] a, input logic [7:0] d);
        send(DIR_WRITE, a, d);
        @(negedge clk);
        idle();
    endtask : write

    task automatic wait_rsp(input logic conv, output logic [23:0] d,
                            output int t);
        int n;
        n = 0;
        @(negedge clk);
        while (!(rsp_valid === 1'h1 && rsp_conv === conv) && n < 4000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 4000) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, 1'h0, 1'h1);
        end
        d = rsp_data;
        t = cyc;
    endtask : wait_rsp

    task automatic rd(input logic [6:0] a, output logic [23:0] d);
        int t;
        send(DIR_READ, a, 8'h00);
        wait_rsp(1'h0, d, t);
        d = 24'(d[7:0]);
    endtask : rd

    task automatic wait_up(output int n);
        n = 0;
        while (powered_up !== 1'h1 && n < 1000) begin
            @(negedge clk);
            n++;
        end
    endtask : wait_up

    task automatic t_power_up();
        int n;
        check(24'(link_bus.data_out_ready_n), 24'h1);
        wait_up(n);
        check(24'(n + 2 >= STARTUP), 24'h1);
        check(24'({low_side_switch_oe, standby_active}), 24'h0);
        $display("t_power_up done");
    endtask : t_power_up

    task automatic t_regs();
        logic [16:0] tbl [4];
        logic [23:0] d;
        tbl = '{{REG_SDO_LSS, 8'h01, 2'h2}, {REG_STANDBY, 8'h01, 2'h3},
                {REG_SDO_LSS, 8'h00, 2'h1}, {REG_STANDBY, 8'h00, 2'h0}};
        foreach (tbl[i]) begin
            write(tbl[i][16:10], tbl[i][9:2]);
            check(24'({low_side_switch_oe, standby_active}),
                  24'(tbl[i][1:0]));
            rd(tbl[i][16:10], d);
            check(d, 24'(tbl[i][9:2]));
        end
        rd(7'h55, d);
        check(d, 24'h0);
        $display("t_regs done");
    endtask : t_regs

    task automatic t_conv();
        logic [25:0] tbl [5];
        logic [23:0] d;
        int t1;
        int t2;
        tbl = '{{2'h0, 24'h000001}, {2'h0, 24'h000000}, {2'h0, 24'hffffff},
                {2'h1, 24'h000001}, {2'h2, 24'h000000}};
        write(REG_CONV_CTRL, {6'h00, CONV_CONT});
        foreach (tbl[i]) begin
            {over_range_pos, over_range_neg, sample} = tbl[i];
            wait_rsp(1'h1, d, t1);
            wait_rsp(1'h1, d, t1);
            check(d, tbl[i][25] ? FS_POS :
                  tbl[i][24] ? FS_NEG : tbl[i][23:0]);
            wait_rsp(1'h1, d, t2);
            check(24'((t2 - t1 + WORD / 2) / WORD),
                  (tbl[i][25:24] != 2'h0) ? 24'h4 : 24'h1);
        end
        $display("t_conv done");
    endtask : t_conv

    task automatic t_standby();
        logic [23:0] d;
        int n;
        over_range_pos = 1'h0;
        write(REG_STANDBY, 8'h01);
        repeat (2 * WORD) @(negedge clk);
        n = 0;
        repeat (4 * WORD) begin
            @(negedge clk);
            if (rsp_valid === 1'h1 && rsp_conv === 1'h1) n++;
        end
        check(24'(n), 24'h0);
        write(REG_STANDBY, 8'h00);
        check(24'(standby_active), 24'h0);
        wait_rsp(1'h1, d, n);
        write(REG_CONV_CTRL, {6'h00, CONV_STOP});
        repeat (WORD) @(negedge clk);
        write(REG_CONV_CTRL, {6'h00, CONV_SINGLE});
        wait_rsp(1'h1, d, n);
        check(24'(rsp_conv), 24'h1);
        rd(REG_CONV_CTRL, d);
        check(d, 24'(CONV_STOP));
        $display("t_standby done");
    endtask : t_standby

    task automatic t_power_down_n();
        logic [23:0] d;
        int n;
        write(REG_SDO_LSS, 8'h01);
        check(24'(low_side_switch_oe), 24'h1);
        power_down_n = 1'h0;
        repeat (5) @(negedge clk);
        check(24'({low_side_switch_oe, powered_up}), 24'h0);
        power_down_n = 1'h1;
        wait_up(n);
        check(24'(n + 4 >= STARTUP), 24'h1);
        rd(REG_SDO_LSS, d);
        check(d, 24'h0);
        $display("t_power_down_n done");
    endtask : t_power_down_n

    initial begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        $display("Error at %0t: seen %h expected %h", $time, 1'h0, 1'h1);
        conclude();
    end

    initial begin
        resetn = 1'h0;
        power_down_n = 1'h1;
        sample = 24'h000000;
        over_range_pos = 1'h0;
        over_range_neg = 1'h0;
        cmd_valid = 1'h0;
        cmd_write = 1'h0;
        cmd_addr = 7'h00;
        cmd_data = 8'h00;
        repeat (20) @(negedge clk);
        resetn = 1'h1;
        t_power_up();
        t_regs();
        t_conv();
        t_standby();
        t_power_down_n();
        conclude();
    end
endmodule : tb_top
`default_nettype wire
